// ===== verilog/drsc_serial_ctrl.sv
// drsc_serial_ctrl.sv: serial command front end of a dual rheostat
// assumes serial pins already sampled in the clock domain, one word per frame
`timescale 1ns/1ps
`include "drsc_consts.svh"

// Behaviour
// (R01) one serial_in bit enters the shift register per serial clock rise
// (R02) host sends each word most significant bit first
// (R03) chip select low frames a word; command runs when it rises
// (R04) write protect low blocks every write, save and adjustment of wipers or store
// (R05) preset, restore and reset-all still reload wipers under protection
// (R06) host issues a no-op before releasing write protect
// (R07) preset reloads both wipers from the persistent store
// (R08) preset acts on the rising edge of its active-low input
// (R09) store words 0 and 1 hold midscale 512, the rest 0, until the user writes a new value
// (R10) ready flags completion of commands 2,3,8,9,10 and preset
// (R11) address 0 selects first wiper, address 1 the second
// (R12) word is 4 command bits, 4 address bits, two data bytes
// (R13) wipers keep 10 data bits, store words keep 16
// (R14) serial_out repeats input delayed 24 clocks except read-backs
// (R15) reset-all loads every wiper from its saved store word
// (R16) ready low from start of long operation until finished
module drsc_serial_ctrl
  import drsc_pkg::*;
#(
  parameter int NV_CYCLES = `DRSC_NV_CYCLES
) (
  input  wire logic         clock,
  input  wire logic         rst_b,
  input  wire logic         serialClk,
  input  wire logic         serial_in,
  input  wire logic         chipSelect_b,
  input  wire logic         writeProtect_b,
  input  wire logic         hardware_preset_n,
  output logic              serial_out,
  output logic              serialOutEn,
  output logic              ready,
  output drsc_wipers_t      wipers
);

  typedef enum logic [1:0] {DRSC_IDLE, DRSC_BUSY} drsc_state_t;

  // =====================================================================
  // edge detection on sampled pins
  // =====================================================================
  logic sclkPrev_q, csPrev_q, presetPrev_q;
  wire  sclkRise   = serialClk & ~sclkPrev_q;
  wire  csRise     = chipSelect_b & ~csPrev_q;
  wire  presetRise = hardware_preset_n & ~presetPrev_q;       // [R08]

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sclkPrev_q   <= 1'b0;
      csPrev_q     <= 1'b1;
      presetPrev_q <= 1'b1;
    end else begin
      sclkPrev_q   <= serialClk;
      csPrev_q     <= chipSelect_b;
      presetPrev_q <= hardware_preset_n;
    end
  end

  // =====================================================================
  // shift register
  // =====================================================================
  logic [`DRSC_WORD_BITS-1:0] shift_q;
  logic                       loadRead_q;
  logic [`DRSC_STORE_BITS-1:0] readVal_q;
  drsc_word_t word;
  assign word = drsc_word_t'(shift_q);                        // [R12]

  // read-back data replaces the data bytes once a frame starts
  wire csFall = ~chipSelect_b & csPrev_q;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      shift_q <= '0;
    end else if (csFall && loadRead_q) begin
      shift_q <= {shift_q[23:16], readVal_q};
    end else if (sclkRise && !chipSelect_b) begin
      shift_q <= {shift_q[22:0], serial_in};                  // [R01] [R02]
    end
  end

  // msb leaves first, 24 clocks after entering
  assign serial_out  = shift_q[`DRSC_WORD_BITS-1];            // [R14]
  assign serialOutEn = ~chipSelect_b;

  // =====================================================================
  // persistent store and wipers
  // =====================================================================
  logic [`DRSC_STORE_BITS-1:0] store_q [`DRSC_STORE_WORDS];
  logic [`DRSC_WIPER_BITS-1:0] wiper_q [2];
  drsc_state_t state_q;
  localparam int CNT_W = $clog2(NV_CYCLES + 1);
  logic [CNT_W-1:0] busyCnt_q;

  wire        exec    = csRise && state_q == DRSC_IDLE;        // [R03]
  wire        chan    = word.addr[0];                         // [R11]
  wire        prot    = ~writeProtect_b;
  wire        isLong  = word.cmd inside {DRSC_SAVE, DRSC_STORE_WR,
                         DRSC_RESET, DRSC_RD_STORE, DRSC_RD_WIPER};
  wire        reload  = presetRise ||
                        (exec && word.cmd == DRSC_RESET);     // [R05] [R15]
  wire        modOk   = exec && !prot;                        // [R04]

  genvar gi;
  generate
    for (gi = 0; gi < `DRSC_STORE_WORDS; gi++) begin : g_store
      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          store_q[gi] <= (gi < 2) ? `DRSC_MIDSCALE : 16'h0000; // [R09]
        end else if (modOk && word.cmd == DRSC_STORE_WR &&
                     word.addr == 4'(gi)) begin
          store_q[gi] <= word.data;                           // [R04]
        end else if (modOk && word.cmd == DRSC_SAVE && gi < 2 &&
                     chan == 1'(gi)) begin
          store_q[gi] <= {6'h00, wiper_q[1'(gi)]};
        end
      end
    end
    for (gi = 0; gi < 2; gi++) begin : g_wiper
      wire sel = chan == 1'(gi);
      wire [`DRSC_WIPER_BITS-1:0] w = wiper_q[gi];
      logic [`DRSC_WIPER_BITS-1:0] nxt;
      always_comb begin
        nxt = w;
        unique case (word.cmd)
          DRSC_WIPER_WR: if (sel) nxt = word.data[9:0];
          DRSC_DEC6_ONE: if (sel) nxt = w >> 1;
          DRSC_DEC6_ALL: nxt = w >> 1;
          DRSC_DEC1_ONE: if (sel && w != '0) nxt = w - 10'h001;
          DRSC_DEC1_ALL: if (w != '0) nxt = w - 10'h001;
          DRSC_INC6_ONE: if (sel) nxt = {w[8:0], 1'b1};
          DRSC_INC6_ALL: nxt = {w[8:0], 1'b1};
          DRSC_INC1_ONE: if (sel && w != '1) nxt = w + 10'h001;
          DRSC_INC1_ALL: if (w != '1) nxt = w + 10'h001;
          default: nxt = w;
        endcase
      end
      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          wiper_q[gi] <= `DRSC_WIPER_BITS'(`DRSC_MIDSCALE);
        end else if (reload ||
                     (exec && word.cmd == DRSC_RESTORE && sel)) begin
          wiper_q[gi] <= store_q[gi][9:0];                    // [R05] [R07]
        end else if (modOk) begin
          wiper_q[gi] <= nxt;                                 // [R13]
        end
      end
    end
  endgenerate

  assign wipers = '{first: wiper_q[0], second: wiper_q[1]};

  // =====================================================================
  // read-back capture and ready sequencing
  // =====================================================================
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      loadRead_q <= 1'b0;
      readVal_q  <= '0;
    end else if (exec) begin
      loadRead_q <= word.cmd inside {DRSC_RD_STORE, DRSC_RD_WIPER};
      readVal_q  <= (word.cmd == DRSC_RD_STORE) ? store_q[word.addr]
                                                : {6'h00, wiper_q[chan]};
    end else if (csFall) begin
      loadRead_q <= 1'b0;
    end
  end

  wire startLong = presetRise || (exec && isLong &&
                   (!prot || word.cmd inside {DRSC_RESET, DRSC_RD_STORE,
                                              DRSC_RD_WIPER}));
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q   <= DRSC_IDLE;
      busyCnt_q <= '0;
    end else begin
      unique case (state_q)
        DRSC_IDLE: if (startLong) begin
          state_q   <= DRSC_BUSY;                             // [R16]
          busyCnt_q <= CNT_W'(NV_CYCLES - 1);
        end
        DRSC_BUSY: if (busyCnt_q == '0) state_q <= DRSC_IDLE;
                   else busyCnt_q <= busyCnt_q - 1'b1;
        default: state_q <= DRSC_IDLE;
      endcase
    end
  end

  assign ready = state_q == DRSC_IDLE;                        // [R10] [R16]

  // =====================================================================
  // assertions
  // =====================================================================
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  shift_in_a: assert property (sclkRise && !chipSelect_b && !csFall |=>
    shift_q[0] == $past(serial_in)) else $error("bit not shifted"); // [R01]
  exec_cs_a: assert property (csRise && state_q == DRSC_IDLE &&
    word.cmd == DRSC_WIPER_WR && writeProtect_b && !presetRise |=>
    wipers.first == $past(word.data[9:0]) || $past(chan))
    else $error("write not executed on cs rise");          // [R03] [R11]
  protect_a: assert property (!writeProtect_b && !reload &&
    !(exec && word.cmd == DRSC_RESTORE) |=> $stable(wipers))
    else $error("wiper changed under protection");          // [R04]
  reset_all_a: assert property (reload |=>
    wipers.first == $past(store_q[0][9:0]) &&
    wipers.second == $past(store_q[1][9:0]))
    else $error("reload missed");                 // [R05] [R07] [R15]
  preset_edge_a: assert property (!hardware_preset_n && !exec && ready |=>
    ready && $stable(wipers)) else $error("preset fired while low"); // [R08]
  busy_a: assert property (state_q == DRSC_IDLE && startLong |=>
    !ready [*2]) else $error("ready not held low");         // [R10] [R16]
  daisy_a: assert property (sclkRise && !chipSelect_b && !csFall |=>
    serial_out == $past(shift_q[22])) else $error("daisy path broken"); // [R14]
  width_a: assert property (exec && word.cmd == DRSC_WIPER_WR &&
    writeProtect_b && !chan && !presetRise |=> wiper_q[0] ==
    $past(word.data[9:0])) else $error("wiper width wrong");     // [R13]

  c_preset: cover property (presetRise ##1 !ready);
  c_write:  cover property (exec && word.cmd == DRSC_WIPER_WR);
  c_read:   cover property (exec && word.cmd == DRSC_RD_STORE);
  c_prot:   cover property (exec && !writeProtect_b);

endmodule // drsc_serial_ctrl

// ===== verilog/drsc_consts.svh
// drsc_consts.svh: offsets, field positions, reset values and timing counts
// assumes inclusion from the drsc package and the top module
`ifndef DRSC_CONSTS_SVH
`define DRSC_CONSTS_SVH

`define DRSC_WORD_BITS     24
`define DRSC_CMD_MSB       23
`define DRSC_CMD_LSB       20
`define DRSC_ADDR_MSB      19
`define DRSC_ADDR_LSB      16
`define DRSC_DATA_MSB      15
`define DRSC_WIPER_BITS    10
`define DRSC_STORE_BITS    16
`define DRSC_MIDSCALE      16'h0200
`define DRSC_CHAN_FIRST    4'h0
`define DRSC_CHAN_SECOND   4'h1
`define DRSC_STORE_WORDS   16
`define DRSC_NV_TIME_US    25
`define DRSC_NV_CYCLES     ((`DRSC_NV_TIME_US * 1000) / 10)
`define DRSC_LOAD_CYCLES   2

`endif

// ===== verilog/drsc_pkg.sv
// drsc_pkg.sv: command codes and carrier types of the serial front end
// assumes drsc_consts.svh is on the include path
`include "drsc_consts.svh"
package drsc_pkg;

  typedef enum logic [3:0] {
    DRSC_NOP      = 4'h0,
    DRSC_RESTORE  = 4'h1,
    DRSC_SAVE     = 4'h2,
    DRSC_STORE_WR = 4'h3,
    DRSC_DEC6_ONE = 4'h4,
    DRSC_DEC6_ALL = 4'h5,
    DRSC_DEC1_ONE = 4'h6,
    DRSC_DEC1_ALL = 4'h7,
    DRSC_RESET    = 4'h8,
    DRSC_RD_STORE = 4'h9,
    DRSC_RD_WIPER = 4'hA,
    DRSC_WIPER_WR = 4'hB,
    DRSC_INC6_ONE = 4'hC,
    DRSC_INC6_ALL = 4'hD,
    DRSC_INC1_ONE = 4'hE,
    DRSC_INC1_ALL = 4'hF
  } drsc_cmd_t;

  typedef struct packed {
    drsc_cmd_t   cmd;
    logic [3:0]  addr;
    logic [15:0] data;
  } drsc_word_t;

  typedef struct packed {
    logic [9:0] first;
    logic [9:0] second;
  } drsc_wipers_t;

endpackage

// ===== verif/drsc_host_model.sv
// drsc_host_model.sv: host side of the serial command port
// assumes the bench calls send() after reset, one frame at a time
`timescale 1ns/1ps
module drsc_host_model (
  input  wire logic  clock,
  output logic       serialClk,
  output logic       serial_in,
  output logic       chipSelect_b,
  input  wire logic  serial_out,
  input  wire logic  serialOutEn
);
  logic [23:0] echo;
  logic        enBad;
  initial begin
    serialClk    = 1'b0;
    serial_in    = 1'b0;
    chipSelect_b = 1'b1;
    enBad        = 1'b0;
  end
  // ==========================================================
  // frame
  task automatic send(input logic [23:0] w);
    chipSelect_b <= 1'b0;
    repeat (3) @(posedge clock);
    for (int i = 23; i >= 0; i--) begin
      serial_in <= w[i];
      repeat (3) @(posedge clock);
      echo[i] = serial_out;
      if (serialOutEn !== 1'b1) enBad = 1'b1;
      serialClk <= 1'b1;
      repeat (3) @(posedge clock);
      serialClk <= 1'b0;
    end
    repeat (3) @(posedge clock);
    chipSelect_b <= 1'b1;
    // released line: no stale value
    serial_in    <= ~serial_in;
  endtask
endmodule // drsc_host_model

// ===== verif/testbench.sv
// testbench.sv: self-checking bench of the serial front end
// assumes drsc_pkg compiled first and a 100 MHz clock
`timescale 1ns/1ps
module testbench;
  import drsc_pkg::*;
  localparam int NV = 4;
  logic         clock = 1'b0;
  logic         rst_b = 1'b0;
  logic         writeProtect_b = 1'b1;
  logic         hardware_preset_n = 1'b1;
  logic         serialClk, serial_in, chipSelect_b;
  logic         serial_out, serialOutEn, ready;
  drsc_wipers_t wipers;
  int           n_fail = 0;
  int           check_count = 0;
  int           cycles = 0;
  always #5 clock = ~clock;
  drsc_serial_ctrl #(.NV_CYCLES(NV)) drsc_serial_ctrl_i (.clock(clock),
    .rst_b(rst_b), .serialClk(serialClk), .serial_in(serial_in),
    .chipSelect_b(chipSelect_b), .writeProtect_b(writeProtect_b),
    .hardware_preset_n(hardware_preset_n), .serial_out(serial_out),
    .serialOutEn(serialOutEn), .ready(ready), .wipers(wipers));
  drsc_host_model drsc_host_model_i (.clock(clock), .serialClk(serialClk),
    .serial_in(serial_in), .chipSelect_b(chipSelect_b),
    .serial_out(serial_out), .serialOutEn(serialOutEn));
  // ==========================================================
  // helpers
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] c, input logic [3:0] a,
                    input logic [15:0] d);
    drsc_host_model_i.send({c, a, d});
    repeat (6) @(posedge clock);
  endtask
  task automatic wipe(input logic [9:0] f, input logic [9:0] s);
    check({22'h0, wipers.first}, {22'h0, f});
    check({22'h0, wipers.second}, {22'h0, s});
  endtask
  // ready low for NV cycles after the start edge, then high again
  task automatic long_op();
    int k;
    k = 0;
    @(negedge clock);
    while (ready !== 1'b0 && k < 12) begin
      @(negedge clock);
      k++;
    end
    k = 0;
    while (ready === 1'b0 && k < NV + 12) begin
      @(negedge clock);
      k++;
    end
    check(k, NV);
    check({31'h0, ready}, 32'h1);
    repeat (2) @(posedge clock);
  endtask
  // long command: measure ready straight after the frame ends
  task automatic wr_long(input logic [3:0] c, input logic [3:0] a,
                         input logic [15:0] d);
    drsc_host_model_i.send({c, a, d});
    long_op();
  endtask
  task automatic end_of_test();
    if (n_fail == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  // ==========================================================
  // scenarios
  task automatic s_reset();
    wipe(10'h200, 10'h200);
    check({31'h0, ready}, 32'h1);
  endtask
  task automatic s_write();
    wr(4'hB, 4'h0, 16'hFD55);
    wr(4'hB, 4'h1, 16'h03AB);
    wipe(10'h155, 10'h3AB);
    check({8'h0, drsc_host_model_i.echo}, 32'hB0FD55);
    check({31'h0, drsc_host_model_i.enBad}, 32'h0);
  endtask
  task automatic s_protect();
    writeProtect_b <= 1'b0;
    wr(4'hB, 4'h0, 16'h0001);
    wr(4'hE, 4'h1, 16'h0000);
    wr(4'h3, 4'h0, 16'h0077);
    wipe(10'h155, 10'h3AB);
    wr(4'h1, 4'h0, 16'h0000);
    wipe(10'h200, 10'h3AB);
    wr_long(4'h8, 4'h0, 16'h0000);
    wipe(10'h200, 10'h200);
    wr(4'h0, 4'h0, 16'h0000);
    writeProtect_b <= 1'b1;
  endtask
  task automatic s_save();
    wr(4'hB, 4'h0, 16'h0123);
    wr_long(4'h2, 4'h0, 16'h0000);
    wr(4'hB, 4'h0, 16'h0000);
    wr(4'h1, 4'h0, 16'h0000);
    wipe(10'h123, 10'h200);
    wr(4'h0, 4'h0, 16'h0000);
  endtask
  task automatic s_store_read();
    wr_long(4'h3, 4'h1, 16'h8155);
    wr_long(4'h8, 4'h0, 16'h0000);
    wipe(10'h123, 10'h155);
    wr_long(4'h9, 4'h1, 16'h0000);
    wr(4'h0, 4'h0, 16'h0000);
    check({16'h0, drsc_host_model_i.echo[15:0]}, 32'h8155);
  endtask
  task automatic s_preset();
    wr(4'hB, 4'h1, 16'h00AA);
    hardware_preset_n <= 1'b0;
    repeat (20) @(posedge clock);
    wipe(10'h123, 10'h0AA);
    hardware_preset_n <= 1'b1;
    long_op();
    wipe(10'h123, 10'h155);
  endtask
  task automatic s_adjust();
    wr(4'hE, 4'h0, 16'h0000);
    wr(4'h6, 4'h1, 16'h0000);
    wr(4'hC, 4'h0, 16'h0000);
    wr(4'h4, 4'h1, 16'h0000);
    wipe(10'h249, 10'h0AA);
    wr(4'hF, 4'h0, 16'h0000);
    wr(4'h5, 4'h0, 16'h0000);
    wipe(10'h125, 10'h055);
    wr(4'hD, 4'h0, 16'h0000);
    wr(4'h7, 4'h0, 16'h0000);
    wipe(10'h24A, 10'h0AA);
    wr_long(4'hA, 4'h1, 16'h0000);
    wr(4'h0, 4'h0, 16'h0000);
    check({16'h0, drsc_host_model_i.echo[15:0]}, 32'h00AA);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    repeat (2) @(posedge clock);
    s_reset();
    s_write();
    s_protect();
    s_save();
    s_store_read();
    s_preset();
    s_adjust();
    end_of_test();
  end
endmodule // testbench
